//--- dcams_device.sv
// dcams_device: memory device end, command decode and data strobes
// assumes: controller on dcams_link_if, all pins resynchronised here
// What this block does
// [R01] ACTIVE opens row from A0..A12
// [R02] READ/WRITE take column and auto-precharge bit
// [R03] PRECHARGE: A10 low one bank, high all
// [R04] single-bank precharge targets bank on BA
// [R05] mode register set loads opcode from address
// [R06] BA selects base or extended mode register
// [R07] command decoded from chip select, RAS, CAS, WE
// [R08] write beat with mask high is discarded
// [R09] mask driven per beat, sampled both strobe edges
// [R10] lower mask bits 0-7, upper 8-15
// [R11] lower strobe bits 0-7, upper 8-15
// [R12] read strobe edges coincide with read data
// [R13] write strobe centred in each data beat
// [R14] commands ignored while chip select high
// [R15] address and control sampled on CK rise
// [R16] bank commands apply to bank on BA
// [R17] masked beat leaves stored byte unchanged
module dcams_device (
  input wire logic clock,
  input wire logic reset_n,
  dcams_link_if.dev link,
  output logic [dcams_pkg::ADDR_W-1:0] baseModeWord,
  output logic [dcams_pkg::ADDR_W-1:0] extModeWord,
  output logic [dcams_pkg::NUM_BANKS-1:0] bankOpen
);
  import dcams_pkg::*;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00, RD_WAIT = 2'b01, RD_BEAT0 = 2'b10, RD_BEAT1 = 2'b11
  } dcams_rd_e;

  dcams_pins_s pinsNow;
  dcams_pins_s syncA_reg, syncA_next, syncB_reg, syncB_next;
  logic ckPrev_reg, ckPrev_next;
  logic [LANES-1:0] dqsPrev_reg, dqsPrev_next;
  logic [ADDR_W-1:0] openRow_reg [NUM_BANKS];
  logic [ADDR_W-1:0] openRow_next [NUM_BANKS];
  logic [NUM_BANKS-1:0] bankOpen_reg, bankOpen_next;
  logic [ADDR_W-1:0] baseMode_reg, baseMode_next;
  logic [ADDR_W-1:0] extMode_reg, extMode_next;
  dcams_rd_e rdState_reg, rdState_next;
  logic [BA_W-1:0] rdBank_reg, rdBank_next;
  logic [1:0] rdRow_reg, rdRow_next;
  logic [1:0] rdCol_reg, rdCol_next;
  logic rdAp_reg, rdAp_next;
  logic [LANES-1:0] wrArm_reg, wrArm_next;
  logic [LANES-1:0] wrBeat1_reg, wrBeat1_next;
  logic wrActive_reg, wrActive_next;
  logic [BA_W-1:0] wrBank_reg, wrBank_next;
  logic [1:0] wrRow_reg, wrRow_next;
  logic [1:0] wrCol_reg, wrCol_next;
  logic wrAp_reg, wrAp_next;
  logic [DQ_W-1:0] dqOut_reg, dqOut_next;
  logic dqsOut_reg, dqsOut_next;
  logic oe_reg, oe_next;
  logic [DQ_W-1:0] mem_reg [MEM_DEPTH];
  logic [DQ_W-1:0] mem_next [MEM_DEPTH];
  logic ckRise;
  logic ckFall;
  logic wrEdge;
  dcams_cmd_e cmd;
  logic [MEM_IDX_W-1:0] wrIdx;

  assign pinsNow = '{ck: link.ck,
    cmd: {link.csN, link.rasN, link.casN, link.weN},
    ba: link.ba, addr: link.addr, dm: link.dm, dq: link.dq,
    dqs: link.dqs};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    wrEdge = 1'b0;
    wrIdx = '0;
    syncA_next = pinsNow;
    syncB_next = syncA_reg;
    ckPrev_next = syncB_reg.ck;
    dqsPrev_next = syncB_reg.dqs;
    openRow_next = openRow_reg;
    bankOpen_next = bankOpen_reg;
    baseMode_next = baseMode_reg;
    extMode_next = extMode_reg;
    rdState_next = rdState_reg;
    rdBank_next = rdBank_reg;
    rdRow_next = rdRow_reg;
    rdCol_next = rdCol_reg;
    rdAp_next = rdAp_reg;
    wrArm_next = wrArm_reg;
    wrBeat1_next = wrBeat1_reg;
    wrActive_next = wrActive_reg;
    wrBank_next = wrBank_reg;
    wrRow_next = wrRow_reg;
    wrCol_next = wrCol_reg;
    wrAp_next = wrAp_reg;
    dqOut_next = dqOut_reg;
    dqsOut_next = dqsOut_reg;
    oe_next = oe_reg;
    mem_next = mem_reg;
    ckRise = syncB_reg.ck & ~ckPrev_reg; // see [R15]
    ckFall = ~syncB_reg.ck & ckPrev_reg;
    cmd = dcamsDecode(syncB_reg.cmd); // see [R07] [R14]

    // read burst: strobe and data change in the same cycle
    unique case (rdState_reg)
      RD_IDLE: begin end
      RD_WAIT: begin
        if (ckRise) begin
          dqOut_next = mem_reg[memIndex(rdBank_reg, rdRow_reg,
            rdCol_reg)];
          dqsOut_next = 1'b1; // see [R12]
          oe_next = 1'b1;
          rdState_next = RD_BEAT0;
        end
      end
      RD_BEAT0: begin
        if (ckFall) begin
          dqOut_next = mem_reg[memIndex(rdBank_reg, rdRow_reg,
            {rdCol_reg[1], ~rdCol_reg[0]})];
          dqsOut_next = 1'b0; // see [R12]
          rdState_next = RD_BEAT1;
        end
      end
      RD_BEAT1: begin
        if (ckRise) begin
          oe_next = 1'b0;
          rdState_next = RD_IDLE;
          if (rdAp_reg) begin
            bankOpen_next[rdBank_reg] = 1'b0;
          end
        end
      end
    endcase

    // write capture, each lane on its own strobe
    for (int l = 0; l < LANES; l++) begin
      wrEdge = wrBeat1_reg[l] ?
        (dqsPrev_reg[l] & ~syncB_reg.dqs[l]) :
        (~dqsPrev_reg[l] & syncB_reg.dqs[l]); // see [R09] [R11] [R13]
      if (wrArm_reg[l] && wrEdge) begin
        wrIdx = memIndex(wrBank_reg, wrRow_reg,
          {wrCol_reg[1], wrCol_reg[0] ^ wrBeat1_reg[l]});
        if (!syncB_reg.dm[l]) begin // see [R08] [R10] [R17]
          mem_next[wrIdx][l*LANE_W +: LANE_W] =
            syncB_reg.dq[l*LANE_W +: LANE_W];
        end
        if (wrBeat1_reg[l]) begin
          wrArm_next[l] = 1'b0;
        end else begin
          wrBeat1_next[l] = 1'b1;
        end
      end
    end
    if (wrActive_reg && wrArm_next == '0) begin
      wrActive_next = 1'b0;
      if (wrAp_reg) begin
        bankOpen_next[wrBank_reg] = 1'b0;
      end
    end
    // commands, taken on the sampled link clock rise
    if (ckRise) begin
      unique case (cmd)
        CMD_ACT: begin
          openRow_next[syncB_reg.ba] = syncB_reg.addr; // see [R01] [R16]
          bankOpen_next[syncB_reg.ba] = 1'b1;
        end
        CMD_RD: begin
          rdBank_next = syncB_reg.ba; // see [R16]
          rdRow_next = openRow_reg[syncB_reg.ba][1:0];
          rdCol_next = syncB_reg.addr[1:0]; // see [R02]
          rdAp_next = syncB_reg.addr[AP_BIT]; // see [R02]
          rdState_next = RD_WAIT;
        end
        CMD_WR: begin
          wrBank_next = syncB_reg.ba; // see [R16]
          wrRow_next = openRow_reg[syncB_reg.ba][1:0];
          wrCol_next = syncB_reg.addr[1:0]; // see [R02]
          wrAp_next = syncB_reg.addr[AP_BIT]; // see [R02]
          wrArm_next = '1;
          wrBeat1_next = '0;
          wrActive_next = 1'b1;
        end
        CMD_PRE: begin
          if (syncB_reg.addr[AP_BIT]) begin // see [R03]
            bankOpen_next = '0;
          end else begin
            bankOpen_next[syncB_reg.ba] = 1'b0; // see [R04] [R16]
          end
        end
        CMD_MRS: begin
          if (syncB_reg.ba == BA_MODE_BASE) begin // see [R06]
            baseMode_next = syncB_reg.addr; // see [R05]
          end else if (syncB_reg.ba == BA_MODE_EXT) begin
            extMode_next = syncB_reg.addr; // see [R05]
          end
        end
        CMD_BST: begin
          if (rdState_reg != RD_IDLE) begin
            oe_next = 1'b0;
            rdState_next = RD_IDLE;
          end
        end
        CMD_REF, CMD_NOP, CMD_DESEL: begin end
      endcase
    end
  end
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      ckPrev_reg <= 1'b0;
      dqsPrev_reg <= '0;
      openRow_reg <= '{default: '0};
      bankOpen_reg <= '0;
      baseMode_reg <= '0;
      extMode_reg <= '0;
      rdState_reg <= RD_IDLE;
      rdBank_reg <= '0;
      rdRow_reg <= '0;
      rdCol_reg <= '0;
      rdAp_reg <= 1'b0;
      wrArm_reg <= '0;
      wrBeat1_reg <= '0;
      wrActive_reg <= 1'b0;
      wrBank_reg <= '0;
      wrRow_reg <= '0;
      wrCol_reg <= '0;
      wrAp_reg <= 1'b0;
      dqOut_reg <= '0;
      dqsOut_reg <= 1'b0;
      oe_reg <= 1'b0;
      mem_reg <= '{default: '0};
    end else begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
      ckPrev_reg <= ckPrev_next;
      dqsPrev_reg <= dqsPrev_next;
      openRow_reg <= openRow_next;
      bankOpen_reg <= bankOpen_next;
      baseMode_reg <= baseMode_next;
      extMode_reg <= extMode_next;
      rdState_reg <= rdState_next;
      rdBank_reg <= rdBank_next;
      rdRow_reg <= rdRow_next;
      rdCol_reg <= rdCol_next;
      rdAp_reg <= rdAp_next;
      wrArm_reg <= wrArm_next;
      wrBeat1_reg <= wrBeat1_next;
      wrActive_reg <= wrActive_next;
      wrBank_reg <= wrBank_next;
      wrRow_reg <= wrRow_next;
      wrCol_reg <= wrCol_next;
      wrAp_reg <= wrAp_next;
      dqOut_reg <= dqOut_next;
      dqsOut_reg <= dqsOut_next;
      oe_reg <= oe_next;
      mem_reg <= mem_next;
    end
  end
  assign link.dqDevOut = dqOut_reg;
  assign link.dqDevOe = {LANES{oe_reg}};
  assign link.dqsDevOut = {LANES{dqsOut_reg}}; // see [R11]
  assign link.dqsDevOe = {LANES{oe_reg}};
  assign baseModeWord = baseMode_reg;
  assign extModeWord = extMode_reg;
  assign bankOpen = bankOpen_reg;
endmodule : dcams_device

//--- dcams_pkg.sv
// dcams_pkg: constants and types shared by both ends of the link
// assumes: both ends run on one 100 MHz clock
package dcams_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int LINK_CK_PERIOD_NS = 80;
  localparam int CK_PHASES = LINK_CK_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam int PHASE_W = 3;
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(CK_PHASES - 1);
  localparam logic [PHASE_W-1:0] PHASE_FALL = PHASE_W'(CK_PHASES / 2);
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_CMD_END = 6'h08;
  localparam logic [CNT_W-1:0] CNT_WR_BEAT0 = 6'h0C;
  localparam logic [CNT_W-1:0] CNT_WR_DQS_RISE = 6'h0E;
  localparam logic [CNT_W-1:0] CNT_WR_BEAT1 = 6'h10;
  localparam logic [CNT_W-1:0] CNT_WR_DQS_FALL = 6'h12;
  localparam logic [CNT_W-1:0] CNT_WR_END = 6'h14;
  localparam logic [CNT_W-1:0] CNT_RD_TIMEOUT = 6'h28;
  // ------------------------------------------------------------
  // widths and field positions
  // ------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int DQ_W = 16;
  localparam int AP_BIT = 10;
  localparam int MEM_IDX_W = 6;
  localparam int MEM_DEPTH = 64;
  localparam logic [BA_W-1:0] BA_MODE_BASE = 2'h0;
  localparam logic [BA_W-1:0] BA_MODE_EXT = 2'h1;
  localparam logic [3:0] PINS_AT_RESET = 4'hF;
  // ------------------------------------------------------------
  // commands, coded as {csN, rasN, casN, weN}
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_MRS = 4'h0, CMD_REF = 4'h1, CMD_PRE = 4'h2, CMD_ACT = 4'h3,
    CMD_WR = 4'h4, CMD_RD = 4'h5, CMD_BST = 4'h6, CMD_NOP = 4'h7,
    CMD_DESEL = 4'h8
  } dcams_cmd_e;

  function automatic dcams_cmd_e dcamsDecode(input logic [3:0] pins);
    if (pins[3]) begin
      return CMD_DESEL;
    end
    return dcams_cmd_e'(pins);
  endfunction : dcamsDecode

  // small array: bank, two row bits, two column bits
  function automatic logic [MEM_IDX_W-1:0] memIndex(
    input logic [BA_W-1:0] bank, input logic [1:0] row,
    input logic [1:0] col);
    return {bank, row, col};
  endfunction : memIndex

  typedef struct packed {
    logic ck;
    logic [3:0] cmd;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] dm;
    logic [DQ_W-1:0] dq;
    logic [LANES-1:0] dqs;
  } dcams_pins_s;
endpackage : dcams_pkg

//--- dcams_link_if.sv
// dcams_link_if: memory link pins between controller and device
// assumes: two-way pins resolved here from per-lane enables
interface dcams_link_if;
  import dcams_pkg::*;
  logic ck;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0] dm;
  logic [DQ_W-1:0] dqCtlOut;
  logic [LANES-1:0] dqCtlOe;
  logic [LANES-1:0] dqsCtlOut;
  logic [LANES-1:0] dqsCtlOe;
  logic [DQ_W-1:0] dqDevOut;
  logic [LANES-1:0] dqDevOe;
  logic [LANES-1:0] dqsDevOut;
  logic [LANES-1:0] dqsDevOe;
  logic [DQ_W-1:0] dq;
  logic [LANES-1:0] dqs;

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign dq[l*LANE_W +: LANE_W] = dqCtlOe[l] ?
      dqCtlOut[l*LANE_W +: LANE_W] :
      (dqDevOe[l] ? dqDevOut[l*LANE_W +: LANE_W] : '0);
    assign dqs[l] = dqsCtlOe[l] ? dqsCtlOut[l] :
      (dqsDevOe[l] & dqsDevOut[l]);
  end

  modport ctl (output ck, csN, rasN, casN, weN, ba, addr, dm,
    dqCtlOut, dqCtlOe, dqsCtlOut, dqsCtlOe, input dq, dqs);
  modport dev (input ck, csN, rasN, casN, weN, ba, addr, dm, dq, dqs,
    output dqDevOut, dqDevOe, dqsDevOut, dqsDevOe);
endinterface : dcams_link_if

//--- dcams_controller.sv
// dcams_controller: link master, one command at a time
// assumes: dcams_device on the far end of dcams_link_if
module dcams_controller (
  input wire logic clock,
  input wire logic reset_n,
  dcams_link_if.ctl link,
  input wire logic reqValid,
  output logic reqReady,
  input wire dcams_pkg::dcams_cmd_e reqCmd,
  input wire logic [dcams_pkg::BA_W-1:0] reqBank,
  input wire logic [dcams_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [2*dcams_pkg::DQ_W-1:0] reqWrData,
  input wire logic [2*dcams_pkg::LANES-1:0] reqWrMask,
  output logic rdValid,
  output logic [2*dcams_pkg::DQ_W-1:0] rdData
);
  import dcams_pkg::*;

  typedef enum logic [1:0] {
    C_IDLE = 2'b00, C_CMD = 2'b01, C_WRITE = 2'b10, C_READ = 2'b11
  } dcams_ctl_e;

  dcams_ctl_e state_reg, state_next;
  logic [PHASE_W-1:0] phase_reg, phase_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic ck_reg, ck_next;
  logic [3:0] pins_reg, pins_next;
  logic [BA_W-1:0] ba_reg, ba_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [LANES-1:0] dm_reg, dm_next;
  logic [DQ_W-1:0] dq_reg, dq_next;
  logic [LANES-1:0] dqOe_reg, dqOe_next;
  logic [LANES-1:0] dqs_reg, dqs_next;
  logic [2*DQ_W-1:0] wrData_reg, wrData_next;
  logic [2*LANES-1:0] wrMask_reg, wrMask_next;
  logic isWr_reg, isWr_next;
  logic isRd_reg, isRd_next;
  logic [DQ_W-1:0] sDqA_reg, sDqA_next, sDqB_reg, sDqB_next;
  logic [LANES-1:0] sDqsA_reg, sDqsA_next, sDqsB_reg, sDqsB_next;
  logic [LANES-1:0] dqsPrev_reg, dqsPrev_next;
  logic [LANES-1:0] rdBeat1_reg, rdBeat1_next;
  logic [LANES-1:0] rdDone_reg, rdDone_next;
  logic [2*DQ_W-1:0] rdData_reg, rdData_next;
  logic rdValid_reg, rdValid_next;
  logic edgeSeen;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    edgeSeen = 1'b0;
    phase_next = (phase_reg == PHASE_LAST) ? '0 :
      phase_reg + PHASE_W'(1);
    // link clock from divider, high in first half
    ck_next = (phase_next < PHASE_FALL);
    state_next = state_reg;
    cnt_next = cnt_reg + CNT_W'(1);
    pins_next = pins_reg;
    ba_next = ba_reg;
    addr_next = addr_reg;
    dm_next = dm_reg;
    dq_next = dq_reg;
    dqOe_next = dqOe_reg;
    dqs_next = dqs_reg;
    wrData_next = wrData_reg;
    wrMask_next = wrMask_reg;
    isWr_next = isWr_reg;
    isRd_next = isRd_reg;
    sDqA_next = link.dq;
    sDqB_next = sDqA_reg;
    sDqsA_next = link.dqs;
    sDqsB_next = sDqsA_reg;
    dqsPrev_next = sDqsB_reg;
    rdBeat1_next = rdBeat1_reg;
    rdDone_next = rdDone_reg;
    rdData_next = rdData_reg;
    rdValid_next = 1'b0;
    reqReady = (state_reg == C_IDLE) && (phase_next == PHASE_FALL);
    unique case (state_reg)
      C_IDLE: begin
        cnt_next = '0;
        if (reqValid && reqReady) begin
          pins_next = 4'(reqCmd); // see [R07]
          ba_next = reqBank; // see [R04]
          addr_next = reqAddr; // see [R05]
          wrData_next = reqWrData;
          wrMask_next = reqWrMask;
          isWr_next = (reqCmd == CMD_WR);
          isRd_next = (reqCmd == CMD_RD);
          state_next = C_CMD;
        end
      end
      C_CMD: begin
        if (cnt_next == CNT_CMD_END) begin
          pins_next = 4'(CMD_NOP);
          rdBeat1_next = '0;
          rdDone_next = '0;
          state_next = isWr_reg ? C_WRITE :
            (isRd_reg ? C_READ : C_IDLE);
        end
      end
      C_WRITE: begin
        // data and mask on ck edges, strobe in the middle
        if (cnt_next == CNT_WR_BEAT0) begin
          dq_next = wrData_reg[DQ_W-1:0];
          dm_next = wrMask_reg[LANES-1:0]; // see [R09]
          dqOe_next = '1;
          dqs_next = '0;
        end
        if (cnt_next == CNT_WR_DQS_RISE) begin
          dqs_next = '1; // see [R13] [R11]
        end
        if (cnt_next == CNT_WR_BEAT1) begin
          dq_next = wrData_reg[2*DQ_W-1:DQ_W];
          dm_next = wrMask_reg[2*LANES-1:LANES]; // see [R09]
        end
        if (cnt_next == CNT_WR_DQS_FALL) begin
          dqs_next = '0; // see [R13]
        end
        if (cnt_next == CNT_WR_END) begin
          dqOe_next = '0;
          dm_next = '0;
          state_next = C_IDLE;
        end
      end
      C_READ: begin
        for (int l = 0; l < LANES; l++) begin
          edgeSeen = rdBeat1_reg[l] ?
            (dqsPrev_reg[l] & ~sDqsB_reg[l]) :
            (~dqsPrev_reg[l] & sDqsB_reg[l]);
          if (!rdDone_reg[l] && edgeSeen) begin
            // lane data taken on its own strobe edge
            if (rdBeat1_reg[l]) begin
              rdData_next[DQ_W + l*LANE_W +: LANE_W] =
                sDqB_reg[l*LANE_W +: LANE_W]; // see [R11]
              rdDone_next[l] = 1'b1;
            end else begin
              rdData_next[l*LANE_W +: LANE_W] =
                sDqB_reg[l*LANE_W +: LANE_W]; // see [R11]
              rdBeat1_next[l] = 1'b1;
            end
          end
        end
        if (rdDone_next == '1) begin
          rdValid_next = 1'b1;
          state_next = C_IDLE;
        end else if (cnt_next == CNT_RD_TIMEOUT) begin
          state_next = C_IDLE;
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= C_IDLE;
      phase_reg <= PHASE_LAST;
      cnt_reg <= '0;
      ck_reg <= 1'b0;
      pins_reg <= PINS_AT_RESET;
      ba_reg <= '0;
      addr_reg <= '0;
      dm_reg <= '0;
      dq_reg <= '0;
      dqOe_reg <= '0;
      dqs_reg <= '0;
      wrData_reg <= '0;
      wrMask_reg <= '0;
      isWr_reg <= 1'b0;
      isRd_reg <= 1'b0;
      sDqA_reg <= '0;
      sDqB_reg <= '0;
      sDqsA_reg <= '0;
      sDqsB_reg <= '0;
      dqsPrev_reg <= '0;
      rdBeat1_reg <= '0;
      rdDone_reg <= '0;
      rdData_reg <= '0;
      rdValid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      ck_reg <= ck_next;
      pins_reg <= pins_next;
      ba_reg <= ba_next;
      addr_reg <= addr_next;
      dm_reg <= dm_next;
      dq_reg <= dq_next;
      dqOe_reg <= dqOe_next;
      dqs_reg <= dqs_next;
      wrData_reg <= wrData_next;
      wrMask_reg <= wrMask_next;
      isWr_reg <= isWr_next;
      isRd_reg <= isRd_next;
      sDqA_reg <= sDqA_next;
      sDqB_reg <= sDqB_next;
      sDqsA_reg <= sDqsA_next;
      sDqsB_reg <= sDqsB_next;
      dqsPrev_reg <= dqsPrev_next;
      rdBeat1_reg <= rdBeat1_next;
      rdDone_reg <= rdDone_next;
      rdData_reg <= rdData_next;
      rdValid_reg <= rdValid_next;
    end
  end

  assign link.ck = ck_reg;
  assign {link.csN, link.rasN, link.casN, link.weN} = pins_reg;
  assign link.ba = ba_reg;
  assign link.addr = addr_reg;
  assign link.dm = dm_reg;
  assign link.dqCtlOut = dq_reg;
  assign link.dqCtlOe = dqOe_reg;
  assign link.dqsCtlOut = dqs_reg;
  assign link.dqsCtlOe = dqOe_reg;
  assign rdValid = rdValid_reg;
  assign rdData = rdData_reg;
endmodule : dcams_controller

//--- dcams_link_sva.sv
// dcams_link_sva: timing checks on the link pins
// assumes: instantiated beside dcams_link_if, one clock domain
module dcams_link_sva
  import dcams_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ck,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [LANES-1:0] dm,
  input wire logic [LANES-1:0] dqCtlOe,
  input wire logic [LANES-1:0] dqsCtlOut,
  input wire logic [LANES-1:0] dqsCtlOe,
  input wire logic [LANES-1:0] dqDevOe,
  input wire logic [LANES-1:0] dqsDevOut,
  input wire logic [LANES-1:0] dqsDevOe
);
  logic [3:0] cmd;
  assign cmd = {csN, rasN, casN, weN};
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // pin relations
  // ----------------------------------------
  a_ck_period: assert property (
    $rose(ck) |-> ck[*4] ##1 (!ck)[*4] ##1 ck)
    else $error("link clock period wrong");
  a_cmd_held: assert property (
    $changed(cmd) |=> $stable(cmd)[*7])
    else $error("command pins not held");
  a_wr_data_slot: assert property (
    cmd == CMD_WR && $changed(cmd) |-> ##12 $rose(dqCtlOe[0]))
    else $error("write data late or early");
  a_rd_edge_aligned: assert property (
    $rose(dqDevOe[0]) |->
    dqsDevOut[0][*4] ##1 (dqDevOe[0] && !dqsDevOut[0])[*4]
    ##1 !dqDevOe[0])
    else $error("read strobe not with data");
  a_wr_centred: assert property (
    $rose(dqCtlOe[0]) |->
    (!dqsCtlOut[0])[*2] ##1 dqsCtlOut[0][*4]
    ##1 (dqCtlOe[0] && !dqsCtlOut[0])[*2] ##1 !dqCtlOe[0])
    else $error("write strobe not centred");
  a_lane_strobes: assert property (
    dqsCtlOe == dqCtlOe
    && dqsDevOe == dqDevOe && dqCtlOe[0] == dqCtlOe[1])
    else $error("strobe enable apart from data");
  a_no_clash: assert property (
    (dqCtlOe & dqDevOe) == 2'h0)
    else $error("both ends drive data");
  a_dm_quiet: assert property (
    dqCtlOe == 2'h0 |-> dm == 2'h0)
    else $error("mask driven outside write");
  c_read: cover property ($rose(dqDevOe[0]));
  c_write: cover property ($rose(dqCtlOe[0]));
  c_mask: cover property (dqCtlOe[0] && dm == 2'h3);
endmodule : dcams_link_sva

//--- testbench.sv
// testbench: controller and device joined, random traffic checked
// assumes: package, link interface and both ends compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dcams_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic reqValid = 1'b0;
  logic reqReady;
  logic rdValid;
  dcams_cmd_e reqCmd = CMD_NOP;
  logic [1:0] reqBank = 2'h0;
  logic [12:0] reqAddr = 13'h0000;
  logic [31:0] reqWrData = 32'h00000000;
  logic [3:0] reqWrMask = 4'h0;
  logic [31:0] rdData;
  logic [12:0] baseModeWord;
  logic [12:0] extModeWord;
  logic [3:0] bankOpen;
  logic [15:0] mem [64];
  logic [12:0] rowOf [4];
  logic [3:0] openExp = 4'h0;
  logic [12:0] baseExp = 13'h0000;
  logic [12:0] extExp = 13'h0000;
  logic [1:0] bk;
  logic [12:0] ar;
  logic [31:0] wd;
  logic [3:0] wm;
  dcams_cmd_e ign [4] = '{CMD_DESEL, CMD_NOP, CMD_REF, CMD_BST};
  int nErrors = 0;
  int checks = 0;
  integer seed = 32'hEA36;
  always #5 clock = ~clock;
  dcams_link_if link ();
  dcams_controller dcams_controller_i (.clock(clock), .reset_n(reset_n),
    .link(link), .reqValid(reqValid), .reqReady(reqReady),
    .reqCmd(reqCmd), .reqBank(reqBank), .reqAddr(reqAddr),
    .reqWrData(reqWrData), .reqWrMask(reqWrMask), .rdValid(rdValid),
    .rdData(rdData));
  dcams_device dcams_device_i (.clock(clock), .reset_n(reset_n),
    .link(link), .baseModeWord(baseModeWord),
    .extModeWord(extModeWord), .bankOpen(bankOpen));
  dcams_link_sva dcams_link_sva_i (.clock(clock), .reset_n(reset_n),
    .ck(link.ck), .csN(link.csN), .rasN(link.rasN), .casN(link.casN),
    .weN(link.weN), .dm(link.dm), .dqCtlOe(link.dqCtlOe),
    .dqsCtlOut(link.dqsCtlOut), .dqsCtlOe(link.dqsCtlOe),
    .dqDevOe(link.dqDevOe), .dqsDevOut(link.dqsDevOut),
    .dqsDevOe(link.dqsDevOe));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("errors %0d checks %0d", nErrors, checks);
    if (nErrors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic cmpReg(string what, logic [12:0] e, logic [12:0] g);
    checks++;
    if (g !== e) begin
      nErrors++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : cmpReg
  task automatic cmpData(string what, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      nErrors++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : cmpData
  task automatic send(dcams_cmd_e c, logic [1:0] b, logic [12:0] a,
      logic [31:0] d, logic [3:0] m);
    int k;
    k = 0;
    @(posedge clock);
    reqCmd <= c;
    reqBank <= b;
    reqAddr <= a;
    reqWrData <= d;
    reqWrMask <= m;
    reqValid <= 1'b1;
    @(posedge clock);
    while (reqReady !== 1'b1) begin
      k++;
      if (k > 100) begin
        nErrors++;
        give_verdict();
      end
      @(posedge clock);
    end
    reqValid <= 1'b0;
  endtask : send
  // three link clock periods, so device outputs have landed
  task automatic settle();
    repeat (24) @(posedge clock);
    cmpReg("bankOpen", {9'h000, openExp}, {9'h000, bankOpen});
    cmpReg("baseModeWord", baseExp, baseModeWord);
    cmpReg("extModeWord", extExp, extModeWord);
  endtask : settle
  task automatic wr(logic [1:0] b, logic [12:0] a, logic [31:0] d,
      logic [3:0] m);
    logic [5:0] i;
    send(CMD_WR, b, a, d, m);
    for (int t = 0; t < 2; t++) begin
      i = {b, rowOf[b][1:0], a[1:0] ^ {1'b0, t[0]}};
      for (int l = 0; l < 2; l++) begin
        if (!m[t*2+l]) begin
          mem[i][l*8 +: 8] = d[t*16+l*8 +: 8];
        end
      end
    end
  endtask : wr
  task automatic rd(logic [1:0] b, logic [12:0] a);
    int k;
    logic [5:0] i;
    k = 0;
    i = {b, rowOf[b][1:0], a[1:0]};
    send(CMD_RD, b, a, 32'h00000000, 4'h0);
    while (rdValid !== 1'b1) begin
      k++;
      if (k > 60) begin
        nErrors++;
        give_verdict();
      end
      @(posedge clock);
    end
    cmpData("rdData", {mem[i^6'h01], mem[i]}, rdData);
  endtask : rd
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 16'h0000;
    end
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      ar = 13'($random(seed));
      send(CMD_MRS, 2'(j), ar, 32'h00000000, 4'h0);
      if (j == 0) begin
        baseExp = ar;
      end
      if (j == 1) begin
        extExp = ar;
      end
      settle();
    end
    for (int j = 0; j < 4; j++) begin
      rowOf[j] = 13'($random(seed));
      send(CMD_ACT, 2'(j), rowOf[j], 32'h00000000, 4'h0);
      openExp[j] = 1'b1;
      settle();
    end
    for (int j = 0; j < 12; j++) begin
      bk = 2'($random(seed));
      ar = 13'($random(seed)) & 13'h03FF;
      wd = $random(seed);
      wm = (j == 0) ? 4'hF : (j == 1) ? 4'h0 : 4'($random(seed));
      wr(bk, ar, wd, wm);
      rd(bk, ar);
    end
    for (int j = 0; j < 4; j++) begin
      send(ign[j], 2'h0, 13'h0400, 32'h00000000, 4'h0);
      settle();
    end
    send(CMD_PRE, 2'h2, 13'h0000, 32'h00000000, 4'h0);
    openExp[2] = 1'b0;
    settle();
    rd(2'h1, 13'h0401);
    openExp[1] = 1'b0;
    settle();
    send(CMD_PRE, 2'h0, 13'h0400, 32'h00000000, 4'h0);
    openExp = 4'h0;
    settle();
    give_verdict();
  end
endmodule : testbench
